// *** hdl/tod_top.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Level query reports selected modulation's level status
// - Numeric +1/-1/0, text HI/LO/OK
// - First talk numeric, second talk text
// - Display report is default talk output
// - First display item: text, max 74
// - Display text padded to at least 25
// - Second item: cursor weighted sum, decimal
// - Third item: annunciator weighted sum, decimal
// - Items repeat cyclically text, cursor, annunciator
// - Function execution restarts sequence at text
// - Shown messages go out as display text
// - Cursor position n weighs two to n
// - Annunciator sum one bit per lamp
// - HI/LO, modulation, source lamps fixed bits
module tod_top
  import tod_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int TEXT_DEPTH = 74
) (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_rst_n, // Async reset, low
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [ADDR_W-1:0] i_awaddr, // AXI write address
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI byte strobes
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  output logic [1:0] o_bresp, // AXI write response
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  input wire logic [ADDR_W-1:0] i_araddr, // AXI read address
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready, // AXI read data ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  input wire logic i_talk, // Addressed to talk, pin level
  input wire logic i_byte_accept, // Byte taken, rising edge, pin
  output logic [7:0] o_talk_byte, // Talker data byte
  output logic o_talk_valid, // Talker byte available
  output logic o_talk_eom // Last byte of item
);
  typedef struct packed {
    logic talk_s1;
    logic talk_s2;
    logic acc_s1;
    logic acc_s2;
    logic acc_s3;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] text_len;
    logic [CURSOR_W-1:0] cursor;
    logic [ANN_W-1:0] annun;
    logic [5:0] level;
    logic [1:0] mod_sel;
    tod_fsm_t state;
    tod_item_t item;
    logic lvl_mode;
    logic lvl_text;
    logic src_text;
    logic [6:0] idx;
    logic [6:0] len;
    logic [63:0] num_buf;
    logic [7:0] byte_r;
    logic valid_r;
    logic eom_r;
  } tod_regs_t;

  tod_regs_t s_r;
  tod_regs_t s_nxt;
  logic ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;

  function automatic logic [31:0] tod_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Binary to left-justified decimal text, {length, chars}, char 0 in low byte
  function automatic logic [67:0] tod_dec(input logic [25:0] v);
    logic [31:0] bcd;
    logic [3:0] lead;
    logic found;
    logic [63:0] chars;
    int k;
    bcd = 32'h0;
    lead = 4'h0;
    found = 1'b0;
    chars = {8{CH_SPACE}};
    for (int i = 25; i >= 0; i--) begin
      for (int j = 0; j < 8; j++) begin
        if (bcd[j*4+:4] >= 4'd5) begin
          bcd[j*4+:4] = bcd[j*4+:4] + 4'd3;
        end
      end
      bcd = {bcd[30:0], v[i]};
    end
    for (int i = 7; i >= 1; i--) begin
      if (!found && bcd[i*4+:4] == 4'h0) begin
        lead = lead + 4'd1;
      end else begin
        found = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      k = i + int'(lead);
      if (k < 8) begin
        chars[i*8+:8] = CH_ZERO + {4'h0, bcd[(7-k)*4+:4]};
      end
    end
    return {4'd8 - lead, chars};
  endfunction

  function automatic logic tod_in_text(input logic [ADDR_W-1:0] a);
    return (a >= ADDR_W'(TEXT_BASE)) && (a < ADDR_W'(TEXT_BASE) + ADDR_W'({TEXT_MAX, 2'b00}));
  endfunction

  always_comb begin
    logic talk;
    logic accept;
    logic func_exec;
    logic query;
    logic [1:0] q_mod;
    logic [31:0] mw;
    logic [67:0] dec;
    logic [1:0] hl;
    logic [6:0] tl;
    logic [6:0] addr_idx;
    talk = 1'b0;
    accept = 1'b0;
    func_exec = 1'b0;
    query = 1'b0;
    q_mod = 2'h0;
    mw = 32'h0;
    dec = 68'h0;
    hl = 2'h0;
    tl = 7'h0;
    addr_idx = 7'h0;
    s_nxt = s_r;
    ram_we = 1'b0;
    ram_waddr = 7'h0;
    ram_wdata = 8'h00;

    s_nxt.talk_s1 = i_talk;
    s_nxt.talk_s2 = s_r.talk_s1;
    s_nxt.acc_s1 = i_byte_accept;
    s_nxt.acc_s2 = s_r.acc_s1;
    s_nxt.acc_s3 = s_r.acc_s2;
    talk = s_r.talk_s2;
    accept = s_r.acc_s2 & ~s_r.acc_s3;

    // Write channel: address and data taken independently
    if (i_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = i_awaddr;
    end
    if (i_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = i_wdata;
      s_nxt.wstrb = i_wstrb;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      mw = tod_merge(32'h0, s_r.wdata, s_r.wstrb);
      addr_idx = 7'((s_r.awaddr - ADDR_W'(TEXT_BASE)) >> 2);
      if (tod_in_text(s_r.awaddr)) begin
        ram_we = s_r.wstrb[0];
        ram_waddr = addr_idx;
        ram_wdata = s_r.wdata[7:0];
      end else begin
        unique case ({s_r.awaddr[ADDR_W-1:2], 2'b00})
          ADDR_W'(REG_CTRL): func_exec = mw[CTRL_FUNC_BIT];
          ADDR_W'(REG_QUERY): begin
            query = s_r.wstrb[0];
            q_mod = s_r.wdata[1:0];
          end
          ADDR_W'(REG_LEVEL): s_nxt.level = 6'(tod_merge(32'(s_r.level), s_r.wdata, s_r.wstrb));
          ADDR_W'(REG_TEXT_LEN): s_nxt.text_len = 7'(tod_merge(32'(s_r.text_len), s_r.wdata, s_r.wstrb));
          ADDR_W'(REG_CURSOR): s_nxt.cursor = CURSOR_W'(tod_merge(32'(s_r.cursor), s_r.wdata, s_r.wstrb));
          ADDR_W'(REG_ANNUN): s_nxt.annun = ANN_W'(tod_merge(32'(s_r.annun), s_r.wdata, s_r.wstrb));
          ADDR_W'(REG_STATUS): s_nxt.bresp = RESP_OKAY;
          default: s_nxt.bresp = RESP_SLVERR;
        endcase
      end
    end
    if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
    end

    // Read channel; the text store is write-only and reads as zero
    if (i_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0;
      if (!tod_in_text(i_araddr)) begin
        unique case ({i_araddr[ADDR_W-1:2], 2'b00})
          ADDR_W'(REG_CTRL): s_nxt.rdata = 32'h0;
          ADDR_W'(REG_QUERY): s_nxt.rdata = {30'h0, s_r.mod_sel};
          ADDR_W'(REG_LEVEL): s_nxt.rdata = {26'h0, s_r.level};
          ADDR_W'(REG_TEXT_LEN): s_nxt.rdata = {25'h0, s_r.text_len};
          ADDR_W'(REG_CURSOR): s_nxt.rdata = 32'(s_r.cursor);
          ADDR_W'(REG_ANNUN): s_nxt.rdata = 32'(s_r.annun);
          ADDR_W'(REG_STATUS): s_nxt.rdata = {17'h0, s_r.idx, s_r.lvl_text, s_r.lvl_mode, s_r.valid_r,
                                               s_r.talk_s2, s_r.item, s_r.state};
          default: s_nxt.rresp = RESP_SLVERR;
        endcase
      end
    end
    if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Talker output
    tl = (s_r.text_len > TEXT_MAX) ? TEXT_MAX : s_r.text_len;
    unique case (s_r.state)
      ST_IDLE: begin
        s_nxt.valid_r = 1'b0;
        s_nxt.eom_r = 1'b0;
        if (talk) begin
          s_nxt.idx = 7'h0;
          s_nxt.src_text = 1'b0;
          s_nxt.state = ST_SEND;
          if (s_r.lvl_mode) begin
            hl = (s_r.mod_sel == MOD_AM || s_r.mod_sel == MOD_FM || s_r.mod_sel == MOD_PM) ?
                 s_r.level[{s_r.mod_sel, 1'b0}+:2] : 2'b00;
            if (hl[LVL_HI_OFS]) begin
              s_nxt.num_buf = s_r.lvl_text ? {48'h0, CH_I, CH_H} : {48'h0, CH_ONE, CH_PLUS};
              s_nxt.len = 7'd2;
            end else if (hl[LVL_LO_OFS]) begin
              s_nxt.num_buf = s_r.lvl_text ? {48'h0, CH_O, CH_L} : {48'h0, CH_ONE, CH_MINUS};
              s_nxt.len = 7'd2;
            end else begin
              s_nxt.num_buf = s_r.lvl_text ? {48'h0, CH_K, CH_O} : {56'h0, CH_ZERO};
              s_nxt.len = s_r.lvl_text ? 7'd2 : 7'd1;
            end
          end else begin
            unique case (s_r.item)
              ITEM_TEXT: begin
                s_nxt.src_text = 1'b1;
                s_nxt.len = (tl < TEXT_MIN) ? TEXT_MIN : tl;
                s_nxt.state = ST_FETCH;
              end
              ITEM_CURSOR: dec = tod_dec({s_r.cursor, 1'b0});
              ITEM_ANNUN: dec = tod_dec({2'b00, s_r.annun});
              default: dec = tod_dec(26'h0);
            endcase
            if (s_r.item != ITEM_TEXT) begin
              s_nxt.num_buf = dec[63:0];
              s_nxt.len = {3'h0, dec[67:64]};
            end
          end
          if (s_nxt.state == ST_SEND) begin
            s_nxt.byte_r = s_nxt.num_buf[7:0];
            s_nxt.valid_r = 1'b1;
            s_nxt.eom_r = (s_nxt.len == 7'd1);
          end
        end
      end
      ST_FETCH: begin
        if (!talk) begin
          s_nxt.state = ST_IDLE;
        end else begin
          // Characters past the written text are spaces
          s_nxt.byte_r = (s_r.idx < tl) ? ram_rdata : CH_SPACE;
          s_nxt.valid_r = 1'b1;
          s_nxt.eom_r = (s_r.idx == s_r.len - 7'd1);
          s_nxt.state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!talk) begin
          // Aborted mid-item: pointer stays, same item next time
          s_nxt.valid_r = 1'b0;
          s_nxt.eom_r = 1'b0;
          s_nxt.state = ST_IDLE;
        end else if (accept) begin
          s_nxt.valid_r = 1'b0;
          if (s_r.eom_r) begin
            s_nxt.eom_r = 1'b0;
            s_nxt.state = ST_DONE;
            if (s_r.lvl_mode) begin
              s_nxt.lvl_text = ~s_r.lvl_text;
              s_nxt.lvl_mode = ~s_r.lvl_text;
            end else begin
              unique case (s_r.item)
                ITEM_TEXT: s_nxt.item = ITEM_CURSOR;
                ITEM_CURSOR: s_nxt.item = ITEM_ANNUN;
                ITEM_ANNUN: s_nxt.item = ITEM_TEXT;
                default: s_nxt.item = ITEM_TEXT;
              endcase
            end
          end else begin
            s_nxt.idx = s_r.idx + 7'd1;
            if (s_r.src_text) begin
              s_nxt.state = ST_FETCH;
            end else begin
              s_nxt.num_buf = s_r.num_buf >> 8;
              s_nxt.byte_r = s_nxt.num_buf[7:0];
              s_nxt.valid_r = 1'b1;
              s_nxt.eom_r = (s_nxt.idx == s_r.len - 7'd1);
            end
          end
        end
      end
      ST_DONE: begin
        // One item per addressing; wait for talk to drop
        if (!talk) begin
          s_nxt.state = ST_IDLE;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase

    // Software commands win over the talker's own advance
    if (query) begin
      s_nxt.lvl_mode = 1'b1;
      s_nxt.lvl_text = 1'b0;
      s_nxt.mod_sel = q_mod;
    end
    if (func_exec) begin
      s_nxt.item = ITEM_TEXT;
      s_nxt.lvl_mode = 1'b0;
      s_nxt.lvl_text = 1'b0;
    end

    s_nxt.awready = ~s_nxt.aw_got;
    s_nxt.wready = ~s_nxt.w_got;
    s_nxt.arready = ~s_nxt.rvalid;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.text_len <= RST_TEXT_LEN;
      s_r.cursor <= RST_CURSOR;
      s_r.annun <= RST_ANNUN;
      s_r.level <= RST_LEVEL;
      s_r.mod_sel <= MOD_AM;
      s_r.state <= ST_IDLE;
      s_r.item <= ITEM_TEXT;
    end else begin
      s_r <= s_nxt;
    end
  end

  tod_text_ram #(
    .DEPTH(TEXT_DEPTH),
    .AW(7)
  ) u_text (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(ram_we),
    .i_waddr(ram_waddr),
    .i_wdata(ram_wdata),
    .i_raddr(s_nxt.idx),
    .o_rdata(ram_rdata)
  );

  assign o_awready = s_r.awready;
  assign o_wready = s_r.wready;
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = s_r.bresp;
  assign o_arready = s_r.arready;
  assign o_rvalid = s_r.rvalid;
  assign o_rdata = s_r.rdata;
  assign o_rresp = s_r.rresp;
  assign o_talk_byte = s_r.byte_r;
  assign o_talk_valid = s_r.valid_r;
  assign o_talk_eom = s_r.eom_r;
endmodule

// *** hdl/tod_pkg.sv ***
package tod_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_QUERY = 12'h004;
  localparam logic [11:0] REG_LEVEL = 12'h008;
  localparam logic [11:0] REG_TEXT_LEN = 12'h00c;
  localparam logic [11:0] REG_CURSOR = 12'h010;
  localparam logic [11:0] REG_ANNUN = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [11:0] TEXT_BASE = 12'h100;

  // Field positions
  localparam int CTRL_FUNC_BIT = 0;
  localparam int LVL_HI_OFS = 0;
  localparam int LVL_LO_OFS = 1;

  // Modulation selectors
  localparam logic [1:0] MOD_AM = 2'h0;
  localparam logic [1:0] MOD_FM = 2'h1;
  localparam logic [1:0] MOD_PM = 2'h2;

  // Annunciator weights, bit index of each lamp
  localparam int ANN_REMOTE = 0;
  localparam int ANN_LISTEN = 1;
  localparam int ANN_FREQUENCY_INDICATOR_START = 2;
  localparam int ANN_TALK = 3;
  localparam int ANN_SRQ = 4;
  localparam int ANN_FREQUENCY_INDICATOR = 5;
  localparam int ANN_FREQUENCY_INDICATOR_REL = 6;
  localparam int ANN_EMF = 7;
  localparam int ANN_SPECIAL = 8;
  localparam int ANN_SWEEP = 9;
  localparam int ANN_HI = 10;
  localparam int ANN_LO = 11;
  localparam int ANN_PM = 12;
  localparam int ANN_FM = 13;
  localparam int ANN_AM = 14;
  localparam int ANN_AMPL_START = 15;
  localparam int ANN_INT = 16;
  localparam int ANN_EXT = 17;
  localparam int ANN_AC = 18;
  localparam int ANN_DC = 19;
  localparam int ANN_AMPLITUDE_INDICATOR = 20;
  localparam int ANN_AMPL_REL = 21;
  localparam int ANN_STOP = 22;
  localparam int ANN_MSG = 23;
  localparam int ANN_W = ANN_MSG + 1;
  localparam int CURSOR_W = 25;

  // Display text limits
  localparam logic [6:0] TEXT_MAX = 7'd74;
  localparam logic [6:0] TEXT_MIN = 7'd25;

  // Reset values
  localparam logic [6:0] RST_TEXT_LEN = 7'h00;
  localparam logic [24:0] RST_CURSOR = 25'h0;
  localparam logic [23:0] RST_ANNUN = 24'h0;
  localparam logic [5:0] RST_LEVEL = 6'h0;

  // Characters
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_K = 8'h4b;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ITEM_TEXT = 2'b00,
    ITEM_CURSOR = 2'b01,
    ITEM_ANNUN = 2'b11
  } tod_item_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_SEND = 2'b11,
    ST_DONE = 2'b10
  } tod_fsm_t;
endpackage

// *** hdl/tod_text_ram.sv ***
`timescale 1ns/10ps
module tod_text_ram #(
  parameter int DEPTH = 74,
  parameter int AW = 7
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Async reset, low
  input wire logic i_we, // Write enable
  input wire logic [AW-1:0] i_waddr, // Write index
  input wire logic [7:0] i_wdata, // Write character
  input wire logic [AW-1:0] i_raddr, // Read index
  output logic [7:0] o_rdata // Registered read character
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// *** test/tod_top_chk.sv ***
`timescale 1ns/10ps
module tod_top_chk (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_awvalid, // AW valid
  input wire logic o_awready, // AW ready
  input wire logic i_wvalid, // W valid
  input wire logic o_wready, // W ready
  input wire logic o_bvalid, // B valid
  input wire logic i_bready, // B ready
  input wire logic [1:0] o_bresp, // B resp
  input wire logic i_talk, // Talk pin
  input wire logic i_byte_accept, // Accept pin
  input wire logic [7:0] o_talk_byte, // Byte
  input wire logic o_talk_valid, // Offered
  input wire logic o_talk_eom // Last byte
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic acc_d_r;
  logic [6:0] acc_cnt_r;
  // Bytes taken in this addressing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_d_r <= 1'b0;
      acc_cnt_r <= 7'h00;
    end else begin
      acc_d_r <= i_byte_accept;
      if (!i_talk)
        acc_cnt_r <= 7'h00;
      else if (i_byte_accept && !acc_d_r && o_talk_valid && acc_cnt_r != 7'h7f)
        acc_cnt_r <= acc_cnt_r + 7'h01;
    end
  end
  eom_with_valid_a: assert property (o_talk_eom |-> o_talk_valid)
    else $error("eom without valid");
  quiet_idle_a: assert property (!i_talk [*5] |-> !o_talk_valid)
    else $error("byte offered while not talking");
  abort_drop_a: assert property ($fell(i_talk) |-> ##[1:5] !o_talk_valid)
    else $error("abort did not withdraw byte");
  // Sync delay means a start is never sooner than two cycles after talk
  start_late_a: assert property ($rose(o_talk_valid) |-> $past(i_talk, 2) || $past(i_talk, 3))
    else $error("byte offered without talk");
  byte_hold_a: assert property ((i_talk && !i_byte_accept) [*6] ##0 (o_talk_valid && $past(o_talk_valid))
    |-> $stable(o_talk_byte) && $stable(o_talk_eom))
    else $error("byte changed without accept");
  // Checked as the last byte appears; its own accept bumps the count later
  item_max_a: assert property ($rose(o_talk_eom) |-> acc_cnt_r <= 7'h49)
    else $error("item longer than 74");
  b_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  cover property (o_talk_eom && $rose(i_byte_accept));
  cover property ($fell(i_talk) && o_talk_valid);
  cover property (o_bvalid && i_bready);
endmodule
bind tod_top tod_top_chk chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_awvalid(i_awvalid),
  .o_awready(o_awready),
  .i_wvalid(i_wvalid),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .i_bready(i_bready),
  .o_bresp(o_bresp),
  .i_talk(i_talk),
  .i_byte_accept(i_byte_accept),
  .o_talk_byte(o_talk_byte),
  .o_talk_valid(o_talk_valid),
  .o_talk_eom(o_talk_eom)
);

// *** test/tod_ctl_model.sv ***
`timescale 1ns/10ps
module tod_ctl_model (
  input wire logic i_clk, // Clock
  input wire logic [7:0] i_talk_byte, // Byte
  input wire logic i_talk_valid, // Offered
  input wire logic i_talk_eom, // Last byte
  output logic o_talk, // Addressed to talk
  output logic o_byte_accept // Byte taken
);
  initial begin
    o_talk = 1'b0;
    o_byte_accept = 1'b0;
  end
  // One addressing reads one item; stop > 0 unaddresses after that many bytes
  task automatic read_item(input int stop, input int slow, output logic [639:0] item);
    int n;
    logic last;
    item = '0;
    n = 0;
    last = 1'b0;
    o_talk <= 1'b1;
    while (!last && !(stop > 0 && n == stop)) begin
      do @(posedge i_clk); while (i_talk_valid !== 1'b1);
      item = {item[631:0], i_talk_byte};
      last = i_talk_eom;
      n++;
      o_byte_accept <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_byte_accept <= 1'b0;
      repeat (6 + slow) @(posedge i_clk);
    end
    o_talk <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// *** test/tod_top_tb.sv ***
`timescale 1ns/10ps
module tod_top_tb
  import tod_pkg::*;
;
  logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0] i_wstrb;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, talk, acc, o_talk_valid, o_talk_eom;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire [7:0] o_talk_byte;
  int mismatches, checked;
  string t;
  string num[4] = '{"+1", "-1", "0", "0"};
  string txt[4] = '{"HI", "LO", "OK", "OK"};
  logic [11:0] regs[7] = '{REG_CTRL, REG_QUERY, REG_LEVEL, REG_TEXT_LEN, REG_CURSOR, REG_ANNUN, REG_STATUS};

  tod_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_talk(talk), .i_byte_accept(acc), .o_talk_byte(o_talk_byte),
    .o_talk_valid(o_talk_valid), .o_talk_eom(o_talk_eom));
  tod_ctl_model ctl (.i_clk(i_clk), .i_talk_byte(o_talk_byte), .i_talk_valid(o_talk_valid),
    .i_talk_eom(o_talk_eom), .o_talk(talk), .o_byte_accept(acc));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic results;
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_item(input string nm, input logic [639:0] exp, input logic [639:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected '%0s' seen '%0s'", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (!aw && o_awready === 1'b1) begin
        aw = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w && o_wready === 1'b1) begin
        w = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk_reg("bresp", {30'h0, er}, {30'h0, o_bresp});
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk_reg("rdata", ed, o_rdata);
    chk_reg("rresp", {30'h0, er}, {30'h0, o_rresp});
    @(posedge i_clk);
  endtask

  function automatic logic [639:0] s2v(input string s, input int pad);
    logic [639:0] r;
    r = '0;
    for (int i = 0; i < s.len(); i++)
      r = {r[631:0], s[i]};
    for (int i = s.len(); i < pad; i++)
      r = {r[631:0], 8'h20};
    return r;
  endfunction

  task automatic item(input string nm, input int stop, input int slow, input logic [639:0] exp);
    logic [639:0] got;
    ctl.read_item(stop, slow, got);
    if (stop == 0)
      chk_item(nm, exp, got);
  endtask

  task automatic load_text(input string s, input logic [31:0] len);
    for (int i = 0; i < s.len(); i++)
      wr(TEXT_BASE + 12'(4 * i), {24'h0, s[i]}, 4'h1, RESP_OKAY);
    wr(REG_TEXT_LEN, len, 4'hf, RESP_OKAY);
  endtask

  initial begin
    // Hang guard, several times the expected run
    repeat (60000) @(posedge i_clk);
    mismatches++;
    results();
  end

  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    i_awaddr = 12'h000;
    i_araddr = 12'h000;
    i_wdata = 32'h0;
    i_wstrb = 4'h0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    foreach (regs[i])
      rd(regs[i], 32'h0, RESP_OKAY);
    rd(12'h020, 32'h0, RESP_SLVERR);
    wr(12'h024, 32'h1, 4'hf, RESP_SLVERR);
    rd(REG_TEXT_LEN, 32'h0, RESP_OKAY);
    load_text("ERR 12", 32'h6);
    wr(REG_CURSOR, 32'h1000001, 4'hf, RESP_OKAY);
    wr(REG_ANNUN, 32'h830401, 4'hf, RESP_OKAY);
    rd(REG_CURSOR, 32'h1000001, RESP_OKAY);
    item("text", 0, 0, s2v("ERR 12", 25));
    item("cursor part", 1, 0, '0);
    item("cursor", 0, 3, s2v("33554434", 0));
    item("annun", 0, 0, s2v("8586241", 0));
    item("text again", 0, 2, s2v("ERR 12", 25));
    t = "";
    for (int i = 0; i < 74; i++)
      t = $sformatf("%s%c", t, 8'h41 + 8'(i % 26));
    load_text(t, 32'h50);
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    item("long text", 0, 0, s2v(t, 0));
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    item("restart", 0, 0, s2v(t, 0));
    wr(REG_LEVEL, 32'h09, 4'hf, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(REG_QUERY, 32'(m), 4'hf, RESP_OKAY);
      item("level num", 0, 0, s2v(num[m], 0));
      item("level text", 0, 1, s2v(txt[m], 0));
    end
    wr(REG_QUERY, 32'h0, 4'hf, RESP_OKAY);
    wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
    item("cancel", 0, 0, s2v(t, 0));
    results();
  end
endmodule
